//--- rtl/btt_top.sv
// binary tick timer: 8-bit stage counter with read hold, run/clear control and stage interrupts
// Overview of operation
// R01 - an 8-bit binary counter advances on the prescaled slow clock so its stages run 128 Hz down to 1 Hz.
// R02 - stages 128..16 Hz read as bits 0..3 of the low word and 8..1 Hz as bits 0..3 of the high word.
// R03 - after a low word read, carries into the high word wait until the high word is read or the window ends.
// R04 - software reads the low word first, since a high word read freezes nothing.
// R05 - both counter words are read only and writes to them are ignored.
// R06 - reset clears the whole count to zero.
// R07 - writing one to the clear bit zeroes the counter, zero does nothing, and the bit reads zero.
// R08 - a clear while running resumes counting from zero at once, a clear while stopped holds zero.
// R09 - the go bit starts and stops counting, a stopped count is kept, it reads back and resets to zero.
// R10 - falling edges of the 32, 8, 2 and 1 Hz stages set flags 0 to 3.
// R11 - flags are set on their falling edge whatever the enable bits hold.
// R12 - four readable enable bits pass or mask each flag and reset to zero.
// R13 - a flag reads one after its event, writing one clears it, writing zero leaves it.
// R14 - reset clears all four flags.
// R15 - software clears a serviced flag before leaving the handler or the interrupt recurs.
// R16 - the interrupt request is high while any flag is set together with its enable bit.
// R17 - the prescaled slow clock is a count enable and the count advances only while running.
`timescale 1ns/1ns
`default_nettype none
`include "btt_defines.svh"
module btt_top #(
   parameter int HOLD_CYCLES = `BTT_HOLD_CYC
) (
   // clock, reset, clock enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire btt_pkg::btt_addr_t paddr,
   input wire btt_pkg::btt_word_t pwdata,
   output btt_pkg::btt_word_t prdata,
   output logic pready,
   output logic pslverr,
   // prescaled slow oscillator clock (256 Hz square wave, asynchronous)
   input wire logic low_speed_osc,
   // interrupt request
   output logic irq
);
   import btt_pkg::*;

   btt_hold_if hold_link ();

   btt_hold_timer #(
      .HOLD_CYCLES(HOLD_CYCLES)
   ) u_hold (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .hold(hold_link.timer)
   );

   localparam logic [31:0] STAGE_MAP = `BTT_STAGE_MAP;

   logic osc_sync1;
   logic osc_sync2;
   logic osc_prev;
   logic tick_edge;
   logic tick_counter_go;
   btt_nib_t tick_count_low;
   btt_nib_t tick_count_high;
   logic carry_pend;
   btt_count_t tick_stage_bits;
   btt_count_t prev_stage_bits;
   btt_nib_t tick_irq_enable;
   btt_nib_t tick_irq_flag;
   logic [3:0] stage_fall;
   btt_reg_t reg_sel;
   logic captured;
   logic xfer_done;
   logic wr_done;
   logic rd_done;
   logic clear_now;
   logic low_carry;
   btt_word_t next_rdata;

   // slow clock crosses in on two flops; edge is taken after the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_sync1 <= 1'b0;
         osc_sync2 <= 1'b0;
         osc_prev <= 1'b0;
      end else if (ce) begin
         osc_sync1 <= low_speed_osc;
         osc_sync2 <= osc_sync1;
         osc_prev <= osc_sync2;
      end
   end

   assign tick_edge = osc_sync2 & ~osc_prev;

   // address decode
   always_comb begin
      unique case (paddr)
         {`BTT_IDX_CTRL, `BTT_BYTE_LANE}: reg_sel = BTT_REG_CTRL;
         {`BTT_IDX_LOW, `BTT_BYTE_LANE}: reg_sel = BTT_REG_LOW;
         {`BTT_IDX_HIGH, `BTT_BYTE_LANE}: reg_sel = BTT_REG_HIGH;
         {`BTT_IDX_IEN, `BTT_BYTE_LANE}: reg_sel = BTT_REG_IEN;
         {`BTT_IDX_IFLG, `BTT_BYTE_LANE}: reg_sel = BTT_REG_IFLG;
         default: reg_sel = BTT_REG_NONE;
      endcase
   end

   // read data is sampled once per transfer so it comes from flops in the access phase;
   // a setup cycle lost to a low clock enable is made up in the first enabled cycle
   always_comb begin
      next_rdata = `BTT_WORD_ZERO;
      unique case (reg_sel)
         BTT_REG_CTRL: next_rdata[`BTT_BIT_GO] = tick_counter_go;
         BTT_REG_LOW: next_rdata[3:0] = tick_count_low;
         BTT_REG_HIGH: next_rdata[3:0] = tick_count_high;
         BTT_REG_IEN: next_rdata[3:0] = tick_irq_enable;
         BTT_REG_IFLG: next_rdata[3:0] = tick_irq_flag;
         BTT_REG_NONE: next_rdata = `BTT_WORD_ZERO;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `BTT_WORD_ZERO;
         captured <= 1'b0;
      end else if (ce) begin
         if (psel && !captured) begin
            prdata <= next_rdata;
            captured <= 1'b1;
         end else if (xfer_done) begin
            captured <= 1'b0;
         end
      end
   end

   // a low clock enable stretches the access phase instead of dropping the transfer
   assign pready = captured & ce;
   assign pslverr = pready & (reg_sel == BTT_REG_NONE);
   assign xfer_done = psel & penable & pready;
   assign wr_done = xfer_done & pwrite & (reg_sel != BTT_REG_NONE);
   assign rd_done = xfer_done & ~pwrite;

   assign clear_now = wr_done & (reg_sel == BTT_REG_CTRL) & pwdata[`BTT_BIT_CLR]; // R07
   assign hold_link.start = rd_done & (reg_sel == BTT_REG_LOW); // R03
   assign hold_link.hi_read = rd_done & (reg_sel == BTT_REG_HIGH); // R03

   // run control
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_counter_go <= 1'b0;
      end else if (ce && wr_done && reg_sel == BTT_REG_CTRL) begin
         tick_counter_go <= pwdata[`BTT_BIT_GO]; // R09
      end
   end

   assign low_carry = tick_edge & tick_counter_go & (tick_count_low == `BTT_NIB_MAX); // R17

   // counter; a carry blocked by the hold is kept and applied once the hold ends, so no time is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_count_low <= `BTT_NIB_ZERO; // R06
         tick_count_high <= `BTT_NIB_ZERO; // R06
         carry_pend <= 1'b0;
      end else if (ce) begin
         if (clear_now) begin
            tick_count_low <= `BTT_NIB_ZERO; // R08
            tick_count_high <= `BTT_NIB_ZERO; // R08
            carry_pend <= 1'b0;
         end else begin
            if (tick_edge && tick_counter_go) begin
               tick_count_low <= tick_count_low + `BTT_NIB_ONE; // R01
            end
            if (hold_link.holding) begin
               carry_pend <= carry_pend | low_carry; // R03
            end else begin
               tick_count_high <= tick_count_high + {3'h0, carry_pend} + {3'h0, low_carry}; // R01
               carry_pend <= 1'b0;
            end
         end
      end
   end

   // writes to the count words fall through here untouched
   assign tick_stage_bits = {tick_count_high, tick_count_low}; // R02 R05

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_stage_bits <= 8'h00;
      end else if (ce) begin
         prev_stage_bits <= tick_stage_bits;
      end
   end

   // interrupt enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_irq_enable <= `BTT_NIB_ZERO;
      end else if (ce && wr_done && reg_sel == BTT_REG_IEN) begin
         tick_irq_enable <= pwdata[3:0]; // R12
      end
   end

   // stage falling edges set the flags; a set in the clearing cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < `BTT_FLAG_CNT; gi++) begin : g_flag
         localparam int STG = int'(STAGE_MAP[8*gi +: 3]);
         assign stage_fall[gi] = prev_stage_bits[STG] & ~tick_stage_bits[STG]; // R10
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tick_irq_flag[gi] <= 1'b0; // R14
            end else if (ce) begin
               if (stage_fall[gi]) begin
                  tick_irq_flag[gi] <= 1'b1; // R10 R11
               end else if (wr_done && reg_sel == BTT_REG_IFLG && pwdata[gi]) begin
                  tick_irq_flag[gi] <= 1'b0; // R13
               end
            end
         end
      end
   endgenerate

   // registered so the request line never glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(tick_irq_flag & tick_irq_enable); // R16
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   int held_cycles;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         held_cycles <= 0;
      end else if (ce) begin
         if (hold_link.start || !hold_link.holding) begin
            held_cycles <= 0;
         end else begin
            held_cycles <= held_cycles + 1;
         end
      end
   end

   a_clear_zeroes: assert property (clear_now && ce |=> tick_stage_bits == 8'h00) // R07
      else $error("clear did not zero the count");
   a_clear_reads_zero: assert property (xfer_done && !pwrite && reg_sel == BTT_REG_CTRL
      |-> prdata[`BTT_BIT_CLR] == 1'b0) // R07
      else $error("clear bit read back as one");
   a_go_write: assert property (wr_done && reg_sel == BTT_REG_CTRL
      |=> tick_counter_go == $past(pwdata[`BTT_BIT_GO])) // R09
      else $error("go bit did not take the written value");
   a_stop_keeps: assert property (!tick_counter_go && !clear_now && !carry_pend |=> $stable(tick_stage_bits)) // R09
      else $error("stopped counter changed");
   a_run_advance: assert property (ce && tick_edge && tick_counter_go && !clear_now
      |=> tick_count_low == $past(tick_count_low) + `BTT_NIB_ONE) // R17
      else $error("running counter missed a tick");
   a_hold_after_low: assert property (hold_link.start && ce |=> hold_link.holding [*2]) // R03
      else $error("low read did not start the hold");
   a_hold_freeze: assert property (hold_link.holding && !clear_now |=> $stable(tick_count_high)) // R03
      else $error("high word moved during hold");
   a_hold_bound: assert property (held_cycles <= HOLD_CYCLES) // R03
      else $error("hold outlasted its window");
   a_hi_read_ends: assert property (hold_link.hi_read && !hold_link.start && ce |=> !hold_link.holding) // R03
      else $error("high read left the hold on");
   a_flag_set: assert property (ce && stage_fall[0] |=> tick_irq_flag[0]) // R10 R11
      else $error("32 Hz edge did not set its flag");
   a_flag_clear: assert property (ce && wr_done && reg_sel == BTT_REG_IFLG && pwdata[3] && !stage_fall[3]
      |=> !tick_irq_flag[3]) // R13
      else $error("write one did not clear the 1 Hz flag");
   a_irq_follows: assert property (ce |=> irq == $past(|(tick_irq_flag & tick_irq_enable))) // R16
      else $error("interrupt request disagrees with flags and enables");

   c_hold_by_read: cover property (hold_link.holding ##1 hold_link.hi_read);
   c_clear_running: cover property (clear_now && tick_counter_go);
   c_one_hz_flag: cover property (stage_fall[3]);
   c_irq_raised: cover property ($rose(irq));
endmodule : btt_top
`default_nettype wire

//--- rtl/btt_defines.svh
// register indices, field positions, reset values and timing constants of the tick timer
`ifndef BTT_DEFINES_SVH
`define BTT_DEFINES_SVH
`define BTT_IDX_CTRL 16'hFF74
`define BTT_IDX_LOW 16'hFF75
`define BTT_IDX_HIGH 16'hFF76
`define BTT_IDX_IEN 16'hFFE5
`define BTT_IDX_IFLG 16'hFFF5
`define BTT_BYTE_LANE 2'h0
`define BTT_BIT_GO 0
`define BTT_BIT_CLR 1
`define BTT_NIB_ZERO 4'h0
`define BTT_NIB_MAX 4'hF
`define BTT_NIB_ONE 4'h1
`define BTT_WORD_ZERO 32'h0
`define BTT_FLAG_CNT 4
`define BTT_STAGE_MAP 32'h07060402
`define BTT_CLK_NS 100
`define BTT_HOLD_MIN_NS 480000
`define BTT_HOLD_MAX_NS 1500000
`define BTT_HOLD_CYC ((`BTT_HOLD_MIN_NS + `BTT_CLK_NS - 1) / `BTT_CLK_NS)
`define BTT_HOLD_ZERO 16'h0
`define BTT_HOLD_ONE 16'h1
`endif

//--- rtl/btt_pkg.sv
// types shared by the tick timer modules
package btt_pkg;
   typedef logic [3:0] btt_nib_t;
   typedef logic [7:0] btt_count_t;
   typedef logic [31:0] btt_word_t;
   typedef logic [17:0] btt_addr_t;
   typedef logic [15:0] btt_hold_cnt_t;
   typedef enum {BTT_FREE, BTT_HELD} btt_hold_state_t;
   typedef enum {BTT_REG_CTRL, BTT_REG_LOW, BTT_REG_HIGH, BTT_REG_IEN, BTT_REG_IFLG, BTT_REG_NONE} btt_reg_t;
endpackage : btt_pkg

//--- rtl/btt_hold_if.sv
// hold request and status between the register logic and the hold window timer
`timescale 1ns/1ns
`default_nettype none
interface btt_hold_if;
   logic start;
   logic hi_read;
   logic holding;
   modport ctrl (output start, output hi_read, input holding);
   modport timer (input start, input hi_read, output holding);
endinterface : btt_hold_if
`default_nettype wire

//--- rtl/btt_hold_timer.sv
// hold window timer: keeps the high word frozen after a low word read
`timescale 1ns/1ns
`default_nettype none
`include "btt_defines.svh"
module btt_hold_timer #(
   parameter int HOLD_CYCLES = `BTT_HOLD_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // hold handshake
   btt_hold_if.timer hold
);
   import btt_pkg::*;

   btt_hold_state_t state;
   btt_hold_cnt_t remain;

   // a fresh low read restarts the window; the high read ends it early
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= BTT_FREE;
         remain <= `BTT_HOLD_ZERO;
      end else if (ce) begin
         if (hold.start) begin
            state <= BTT_HELD;
            remain <= btt_hold_cnt_t'(HOLD_CYCLES - 1);
         end else begin
            unique case (state)
               BTT_FREE: begin
                  remain <= `BTT_HOLD_ZERO;
               end
               BTT_HELD: begin
                  if (hold.hi_read || remain == `BTT_HOLD_ZERO) begin
                     state <= BTT_FREE;
                  end else begin
                     remain <= remain - `BTT_HOLD_ONE;
                  end
               end
            endcase
         end
      end
   end

   assign hold.holding = (state == BTT_HELD);
endmodule : btt_hold_timer
`default_nettype wire

//--- bench/btt_osc_model.sv
// prescaled slow oscillator source that emits counted pulses
`timescale 1ns/1ns
`default_nettype none
module btt_osc_model #(
   parameter int HALF_NS = 730
) (
   // prescaled clock, low while idle
   output var logic low_speed_osc
);
   initial low_speed_osc = 1'b0;
   // half period off the pclk grid so the synchroniser sees many phases
   task automatic emit(input int n);
      repeat (n) begin
         #HALF_NS low_speed_osc = 1'b1;
         #HALF_NS low_speed_osc = 1'b0;
      end
   endtask : emit
endmodule : btt_osc_model
`default_nettype wire

//--- bench/btt_top_tb.sv
// self-checking testbench of the binary tick timer over apb
`timescale 1ns/1ns
`default_nettype none
`include "btt_defines.svh"
module btt_top_tb;
   import btt_pkg::*;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, low_speed_osc, irq;
   btt_addr_t paddr;
   btt_word_t pwdata, prdata;
   logic [32:0] exp_q[$];
   int fail_count = 0;
   int n_compared = 0;
   btt_nib_t ien;

   // hold shortened for simulation, long enough to span one slow pulse
   btt_top #(.HOLD_CYCLES(60)) i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .low_speed_osc(low_speed_osc), .irq(irq));
   btt_osc_model i_osc (.low_speed_osc(low_speed_osc));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic wrap_up;
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [32:0] seen, input logic [32:0] want);
      n_compared++;
      if (seen !== want) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : chk

   function automatic logic [32:0] ok(input btt_nib_t v);
      return {1'b0, 28'h0000000, v};
   endfunction : ok

   // entered right after a rising edge; leaves one idle cycle behind
   task automatic apb(input logic wr, input logic [15:0] idx, input btt_nib_t v);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= btt_addr_t'({idx, 2'h0});
      pwdata <= {28'($urandom), v};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rd(input logic [15:0] idx, input logic [32:0] want);
      exp_q.push_back(want);
      apb(1'b0, idx, 4'h0);
   endtask : rd

   task automatic settle;
      repeat (5) @(posedge pclk);
   endtask : settle

   // read results are judged at the completing edge, before it updates anything
   always @(posedge pclk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() == 0) chk(33'h1FFFFFFFF, 33'h0);
         else chk({pslverr, prdata}, exp_q.pop_front());
      end
   end

   initial begin
      #5000000;
      fail_count++;
      wrap_up();
   end

   initial begin
      void'($urandom(32'h8A1D2961));
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`BTT_IDX_CTRL, ok(4'h0));
      rd(`BTT_IDX_LOW, ok(4'h0));
      rd(`BTT_IDX_HIGH, ok(4'h0));
      rd(`BTT_IDX_IEN, ok(4'h0));
      rd(`BTT_IDX_IFLG, ok(4'h0));
      rd(16'h1234, 33'h100000000);
      i_osc.emit(3);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h0));
      ien = btt_nib_t'($urandom);
      apb(1'b1, `BTT_IDX_IEN, ien);
      // drop the clock enable across the next read so the stretched access is exercised
      fork
         begin
            @(posedge pclk);
            ce <= 1'b0;
            repeat (3) @(posedge pclk);
            ce <= 1'b1;
         end
      join_none
      rd(`BTT_IDX_IEN, ok(ien));
      apb(1'b1, `BTT_IDX_IEN, 4'h0);
      apb(1'b1, `BTT_IDX_LOW, btt_nib_t'($urandom));
      apb(1'b1, `BTT_IDX_HIGH, 4'hF);
      rd(`BTT_IDX_LOW, ok(4'h0));
      rd(`BTT_IDX_HIGH, ok(4'h0));
      apb(1'b1, `BTT_IDX_CTRL, 4'h1);
      rd(`BTT_IDX_CTRL, ok(4'h1));
      i_osc.emit(5);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h5));
      apb(1'b1, `BTT_IDX_CTRL, 4'h0);
      i_osc.emit(3);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h5));
      apb(1'b1, `BTT_IDX_CTRL, 4'h2);
      rd(`BTT_IDX_CTRL, ok(4'h0));
      i_osc.emit(2);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h0));
      apb(1'b1, `BTT_IDX_CTRL, 4'h1);
      i_osc.emit(16);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h0));
      rd(`BTT_IDX_HIGH, ok(4'h1));
      rd(`BTT_IDX_IFLG, ok(4'h1));
      chk({32'h0, irq}, 33'h0);
      apb(1'b1, `BTT_IDX_IEN, 4'hF);
      settle();
      chk({32'h0, irq}, 33'h1);
      apb(1'b1, `BTT_IDX_IFLG, 4'h0);
      rd(`BTT_IDX_IFLG, ok(4'h1));
      apb(1'b1, `BTT_IDX_IFLG, 4'hF);
      rd(`BTT_IDX_IFLG, ok(4'h0));
      chk({32'h0, irq}, 33'h0);
      // 16 + 240 wraps the count, so every stage falls at least once
      i_osc.emit(240);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h0));
      rd(`BTT_IDX_HIGH, ok(4'h0));
      rd(`BTT_IDX_IFLG, ok(4'hF));
      apb(1'b1, `BTT_IDX_IFLG, 4'hF);
      i_osc.emit(15);
      settle();
      rd(`BTT_IDX_LOW, ok(4'hF));
      i_osc.emit(1);
      settle();
      rd(`BTT_IDX_HIGH, ok(4'h0));
      rd(`BTT_IDX_LOW, ok(4'h0));
      rd(`BTT_IDX_HIGH, ok(4'h1));
      i_osc.emit(15);
      settle();
      rd(`BTT_IDX_LOW, ok(4'hF));
      i_osc.emit(1);
      repeat (70) @(posedge pclk);
      rd(`BTT_IDX_HIGH, ok(4'h2));
      apb(1'b1, `BTT_IDX_CTRL, 4'h3);
      i_osc.emit(4);
      settle();
      rd(`BTT_IDX_LOW, ok(4'h4));
      rd(`BTT_IDX_HIGH, ok(4'h0));
      rd(`BTT_IDX_CTRL, ok(4'h1));
      settle();
      wrap_up();
   end
endmodule : btt_top_tb
`default_nettype wire
